// ---- rtl/msa_pkg.sv ----
// Constants, field layout and carrier types of the serial audio input port
`default_nettype none
package msa_pkg;
   // Geometry
   localparam int unsigned NUM_CHANNELS = 12;
   localparam int unsigned NUM_LINES    = 6;
   localparam int unsigned WORD_W       = 24;
   localparam int unsigned CHAN_W       = 4;
   localparam int unsigned ADDR_W       = 10;

   // Register indices and byte addresses (index times four)
   localparam logic [7:0] REG_FMT_IDX  = 8'h06;
   localparam logic [7:0] REG_PORT_IDX = 8'h07;
   localparam logic [ADDR_W-1:0] ADDR_FMT    = {REG_FMT_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_PORT   = {REG_PORT_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_CHSEL  = 10'h040;
   localparam logic [ADDR_W-1:0] ADDR_SAMPLE = 10'h044;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 10'h048;

   // Reset values
   localparam logic [7:0] FMT_RST  = 8'h01;
   localparam logic [7:0] PORT_RST = 8'h00;

   // Format control fields
   localparam int unsigned FMT_ALIGN_HI = 7;
   localparam int unsigned FMT_ALIGN_LO = 6;
   localparam int unsigned FMT_SLOT_HI  = 5;
   localparam int unsigned FMT_SLOT_LO  = 3;

   // Port control fields
   localparam int unsigned PORT_INTCLK_BIT = 7;
   localparam int unsigned PORT_PULSE_BIT  = 6;
   localparam int unsigned PORT_POL_BIT    = 5;
   localparam int unsigned PORT_SLOT16_BIT = 2;
   localparam int unsigned PORT_EDGE_BIT   = 1;
   localparam int unsigned PORT_MASTER_BIT = 0;

   // Slot mode codes
   localparam logic [2:0] SLOT_TDM4  = 3'h2;
   localparam logic [2:0] SLOT_TDM8  = 3'h3;
   localparam logic [2:0] SLOT_TDM16 = 3'h4;

   // Timing of the generated bit clock
   localparam int unsigned CORE_PERIOD_NS     = 100;
   localparam int unsigned MASTER_BIT_PERIOD_NS = 800;
   localparam int unsigned BIT_HALF_CYCLES =
      MASTER_BIT_PERIOD_NS / (2 * CORE_PERIOD_NS);

   typedef enum logic [1:0] {
      ALIGN_I2S,
      ALIGN_LEFT,
      ALIGN_RIGHT24,
      ALIGN_RIGHT16
   } msa_align_t;

   typedef struct packed {
      logic              valid;
      logic [CHAN_W-1:0] channel;
      logic [WORD_W-1:0] word;
   } msa_sample_t;
endpackage : msa_pkg
`default_nettype wire

// ---- rtl/msa_sample_mem.sv ----
// Small per-channel sample store with registered read data
`default_nettype none
module msa_sample_mem #(
   parameter int unsigned DEPTH  = 12,
   parameter int unsigned WIDTH  = 24,
   parameter int unsigned AWIDTH = 4
) (
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              srst,
   // Write port
   input  wire logic              wrEn,
   input  wire logic [AWIDTH-1:0] wrAddr,
   input  wire logic [WIDTH-1:0]  wrData,
   // Read port
   input  wire logic [AWIDTH-1:0] rdAddr,
   output logic      [WIDTH-1:0]  rdData
);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [WIDTH-1:0] rdData_ff;

   always_ff @(posedge core_clk) begin
      if (wrEn && (32'(wrAddr) < DEPTH)) begin
         mem_ff[wrAddr] <= wrData;
      end
   end

   // Out of range reads give zero
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rdData_ff <= '0;
      end else if (32'(rdAddr) < DEPTH) begin
         rdData_ff <= mem_ff[rdAddr];
      end else begin
         rdData_ff <= '0;
      end
   end

   assign rdData = rdData_ff;
endmodule : msa_sample_mem
`default_nettype wire

// ---- rtl/msa_serial_audio_input.sv ----
// Multichannel serial audio input port with AHB-Lite register access
//
// What this block does
// R1 - All twelve channels share one bit clock and one frame clock.
// R2 - After reset, data is taken as I2S, first bit one bit after frame edge.
// R3 - Format bits 7:6 pick I2S, left, right 24-bit or right 16-bit alignment.
// R4 - Format bits 5:3: 0/1 stereo, 2 TDM4, 3 TDM8, 4 TDM16.
// R5 - Port bit 5 inverts frame clock, swapping left and right.
// R6 - Port bit 1 picks the bit clock edge that latches data.
// R7 - Port bit 0 makes the port drive clocks (master); slave by default.
// R8 - TDM16 on one line, TDM8 on two, TDM4 on three, TDM2 on six.
// R9 - Frame clock works as one bit pulse or 50 percent square wave.
// R10 - Each slot is 16 or 32 bit clocks long in every mode.
// R11 - Stereo: line n carries channels 2n-1 and 2n.
// R12 - TDM4: lines 1 to 3 carry channels 1-4, 5-8, 9-12.
// R13 - TDM8: line 1 carries channels 1-8, line 2 channels 9-12.
// R14 - TDM16: line 1 alone carries channels 1 to 12.
// R15 - Source keeps sample rate within the limit of each mode.
// R16 - TDM data is accepted without a bit clock on the pin.
// R17 - Words shift in MSB first and are handed over once the slot ends.
`default_nettype none
module msa_serial_audio_input
   import msa_pkg::*;
#(
   parameter int unsigned BIT_HALF = msa_pkg::BIT_HALF_CYCLES
) (
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                srst,
   // AHB-Lite slave
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic                     hreadyout,
   output logic                     hresp,
   output logic      [31:0]         hrdata,
   // Bit clock pin
   input  wire logic                bitClockIn,
   output logic                     bitClockOut,
   output logic                     bitClockOeN,
   // Frame clock pin
   input  wire logic                frameClockIn,
   output logic                     frameClockOut,
   output logic                     frameClockOeN,
   // Serial data lines, bit 0 is line 1
   input  wire logic [NUM_LINES-1:0] serialDataLine,
   // Parallel sample stream
   output msa_pkg::msa_sample_t      sampleOut
);
   // Registers and state
   logic [7:0]           fmtCtrl_ff;
   logic [7:0]           portCtrl_ff;
   logic [CHAN_W-1:0]    chanSel_ff;
   logic [15:0]          frameCnt_ff;
   logic                 dpWrite_ff;
   logic                 dpRead_ff;
   logic [ADDR_W-1:0]    dpAddr_ff;
   logic [1:0]           bclkSync_ff;
   logic [1:0]           fclkSync_ff;
   logic [NUM_LINES-1:0] dataS1_ff;
   logic [NUM_LINES-1:0] dataS2_ff;
   logic [7:0]           genCnt_ff;
   logic                 genClk_ff;
   logic [9:0]           mPos_ff;
   logic                 frameOut_ff;
   logic                 bclkPrev_ff;
   logic                 fPrev_ff;
   logic [9:0]           pos_ff;
   logic                 frameSeen_ff;
   logic [31:0]          shreg_ff [NUM_LINES];
   logic [WORD_W-1:0]    cap_ff [NUM_LINES];
   logic [4:0]           capSlot_ff;
   logic                 wrBusy_ff;
   logic [2:0]           wrLine_ff;
   msa_sample_t          sampleOut_ff;
   logic [WORD_W-1:0]    memRd;

   // Configuration decode
   msa_align_t align;
   wire [2:0] slotMode   = fmtCtrl_ff[FMT_SLOT_HI:FMT_SLOT_LO];
   wire       isMaster   = portCtrl_ff[PORT_MASTER_BIT];
   wire       pulseMode  = portCtrl_ff[PORT_PULSE_BIT];
   wire       pol        = portCtrl_ff[PORT_POL_BIT];
   wire       slot16     = portCtrl_ff[PORT_SLOT16_BIT];
   wire       fallEdge   = portCtrl_ff[PORT_EDGE_BIT];
   wire       intClk     = portCtrl_ff[PORT_INTCLK_BIT];
   assign align = msa_align_t'(fmtCtrl_ff[FMT_ALIGN_HI:FMT_ALIGN_LO]); // R3
   // Codes above TDM16 fall back to stereo
   wire [4:0] slotsPerLine = (slotMode == SLOT_TDM16) ? 5'h10 :
                             (slotMode == SLOT_TDM8)  ? 5'h08 :
                             (slotMode == SLOT_TDM4)  ? 5'h04 : 5'h02; // R4
   wire [4:0] slotLenM1 = slot16 ? 5'h0F : 5'h1F; // R10
   wire [9:0] frameBits = slot16 ? {1'b0, slotsPerLine, 4'h0}
                                 : {slotsPerLine, 5'h00};

   // AHB-Lite: zero wait states, always OKAY
   wire apValid = hsel && htrans[1] && hready;
   wire wrFmt   = dpWrite_ff && (dpAddr_ff == ADDR_FMT);
   wire wrPort  = dpWrite_ff && (dpAddr_ff == ADDR_PORT);
   wire wrChsel = dpWrite_ff && (dpAddr_ff == ADDR_CHSEL);
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata = !dpRead_ff                 ? 32'h0000_0000 :
                   (dpAddr_ff == ADDR_FMT)    ? {24'h00_0000, fmtCtrl_ff} :
                   (dpAddr_ff == ADDR_PORT)   ? {24'h00_0000, portCtrl_ff} :
                   (dpAddr_ff == ADDR_CHSEL)  ? {28'h000_0000, chanSel_ff} :
                   (dpAddr_ff == ADDR_SAMPLE) ? {8'h00, memRd} :
                   (dpAddr_ff == ADDR_STATUS) ?
                      {15'h0000, frameSeen_ff, frameCnt_ff} : 32'h0000_0000;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         dpWrite_ff <= 1'b0;
         dpRead_ff  <= 1'b0;
         dpAddr_ff  <= '0;
      end else if (hready) begin
         dpWrite_ff <= apValid && hwrite;
         dpRead_ff  <= apValid && !hwrite;
         dpAddr_ff  <= haddr[ADDR_W-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         fmtCtrl_ff  <= FMT_RST; // R2
         portCtrl_ff <= PORT_RST; // R7
         chanSel_ff  <= '0;
      end else begin
         if (wrFmt)   fmtCtrl_ff  <= hwdata[7:0];
         if (wrPort)  portCtrl_ff <= hwdata[7:0];
         if (wrChsel) chanSel_ff  <= hwdata[CHAN_W-1:0];
      end
   end

   // Pin synchronisers
   always_ff @(posedge core_clk) begin
      if (srst) begin
         bclkSync_ff <= '0;
         fclkSync_ff <= '0;
         dataS1_ff   <= '0;
         dataS2_ff   <= '0;
      end else begin
         bclkSync_ff <= {bclkSync_ff[0], bitClockIn};
         fclkSync_ff <= {fclkSync_ff[0], frameClockIn};
         dataS1_ff   <= serialDataLine;
         dataS2_ff   <= dataS1_ff;
      end
   end

   // Internal bit clock for master and clockless operation
   wire genToggle = (genCnt_ff == 8'(BIT_HALF - 1));
   wire genLaunch = genToggle && (genClk_ff == ~fallEdge);
   wire [9:0] mPosNxt = (mPos_ff >= frameBits - 10'h001) ? 10'h000
                                                         : mPos_ff + 10'h001;
   wire genFrameEff = pulseMode ? (mPosNxt == 10'h000)
                                : (mPosNxt >= {1'b0, frameBits[9:1]}); // R9

   always_ff @(posedge core_clk) begin
      if (srst) begin
         genCnt_ff   <= '0;
         genClk_ff   <= 1'b0;
         mPos_ff     <= '0;
         frameOut_ff <= 1'b0;
      end else begin
         genCnt_ff <= genToggle ? 8'h00 : genCnt_ff + 8'h01;
         if (genToggle) genClk_ff <= ~genClk_ff;
         if (genLaunch) begin
            mPos_ff     <= mPosNxt;
            frameOut_ff <= genFrameEff ^ pol; // R5
         end
      end
   end

   assign bitClockOut   = genClk_ff;
   assign frameClockOut = frameOut_ff;
   assign bitClockOeN   = ~isMaster; // R7
   assign frameClockOeN = ~isMaster; // R7

   // One bit clock and frame clock source for all lines
   wire bclkSrc  = (isMaster || intClk) ? genClk_ff : bclkSync_ff[1]; // R1 R16
   wire frameSrc = isMaster ? frameOut_ff : fclkSync_ff[1];
   wire fEff     = frameSrc ^ pol; // R5
   wire bitTick  = (bclkSrc != bclkPrev_ff) && (bclkSrc == ~fallEdge); // R6
   wire start    = pulseMode ? (fEff && !fPrev_ff)
                             : (!fEff && fPrev_ff); // R9
   wire delay    = (align == ALIGN_I2S); // R2
   // I2S frame edge still carries the last bit of the previous frame
   wire [9:0] dataIdx = (start && !delay) ? 10'h000
                                          : pos_ff + 10'h001 - {9'h000, delay};
   wire bitValid = (frameSeen_ff || (start && !delay)) &&
                   (pos_ff != 10'h3FF) && (dataIdx < frameBits);
   wire [4:0] bitInSlot = slot16 ? {1'b0, dataIdx[3:0]} : dataIdx[4:0];
   wire [4:0] slotIdx   = slot16 ? dataIdx[8:4] : dataIdx[9:5];
   wire slotEnd = bitTick && bitValid && (bitInSlot == slotLenM1); // R10

   always_ff @(posedge core_clk) begin
      if (srst) begin
         bclkPrev_ff  <= 1'b0;
         fPrev_ff     <= 1'b0;
         pos_ff       <= 10'h3FF;
         frameSeen_ff <= 1'b0;
         frameCnt_ff  <= '0;
      end else begin
         bclkPrev_ff <= bclkSrc;
         if (bitTick) begin
            fPrev_ff <= fEff;
            if (start) begin
               pos_ff       <= 10'h000;
               frameSeen_ff <= 1'b1;
               frameCnt_ff  <= frameCnt_ff + 16'h0001;
            end else if (pos_ff != 10'h3FF) begin
               pos_ff <= pos_ff + 10'h001;
            end
         end
      end
   end

   // Word alignment within a completed slot
   function automatic logic [WORD_W-1:0] extract(
      input logic [31:0] s,
      input msa_align_t  a,
      input logic        s16
   );
      if (s16 || (a == ALIGN_RIGHT16)) begin
         extract = {s[15:0], 8'h00}; // R3
      end else if (a == ALIGN_RIGHT24) begin
         extract = s[23:0]; // R3
      end else begin
         extract = s[31:8];
      end
   endfunction : extract

   // Per-line shift and capture, MSB first
   for (genvar l = 0; l < NUM_LINES; l++) begin : g_line
      wire [31:0] shNext = {shreg_ff[l][30:0], dataS2_ff[l]}; // R17
      always_ff @(posedge core_clk) begin
         if (srst) begin
            shreg_ff[l] <= '0;
            cap_ff[l]   <= '0;
         end else if (bitTick && bitValid) begin
            shreg_ff[l] <= shNext;
            if (slotEnd) cap_ff[l] <= extract(shNext, align, slot16); // R17
         end
      end
   end

   // Hand captured words to channels, one line per cycle
   wire [7:0] chanCalc = {5'h00, wrLine_ff} * {3'h0, slotsPerLine}
                         + {3'h0, capSlot_ff}; // R8
   wire chanOk = (capSlot_ff < slotsPerLine) &&
                 (chanCalc < 8'(NUM_CHANNELS)); // R11 R12 R13 R14

   always_ff @(posedge core_clk) begin
      if (srst) begin
         capSlot_ff   <= '0;
         wrBusy_ff    <= 1'b0;
         wrLine_ff    <= '0;
         sampleOut_ff <= '0;
      end else begin
         sampleOut_ff.valid <= wrBusy_ff && chanOk;
         sampleOut_ff.channel <= chanCalc[CHAN_W-1:0];
         sampleOut_ff.word <= cap_ff[wrLine_ff];
         if (slotEnd) begin
            capSlot_ff <= slotIdx;
            wrBusy_ff  <= 1'b1;
            wrLine_ff  <= '0;
         end else if (wrBusy_ff) begin
            if (wrLine_ff != 3'(NUM_LINES - 1)) wrLine_ff <= wrLine_ff + 3'h1;
            else wrBusy_ff <= 1'b0;
         end
      end
   end

   assign sampleOut = sampleOut_ff;

   msa_sample_mem #(
      .DEPTH  (NUM_CHANNELS),
      .WIDTH  (WORD_W),
      .AWIDTH (CHAN_W)
   ) u_mem (
      .core_clk (core_clk),
      .srst     (srst),
      .wrEn     (sampleOut_ff.valid),
      .wrAddr   (sampleOut_ff.channel),
      .wrData   (sampleOut_ff.word),
      .rdAddr   (chanSel_ff),
      .rdData   (memRd)
   );

   // Line that produced the current output word
   logic [2:0] outLine_ff;
   logic [4:0] outSlot_ff;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         outLine_ff <= '0;
         outSlot_ff <= '0;
      end else begin
         outLine_ff <= wrLine_ff;
         outSlot_ff <= capSlot_ff;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   property p_reset_fmt;
      @(posedge core_clk) disable iff (1'b0)
      srst |=> (fmtCtrl_ff == FMT_RST) && (portCtrl_ff == PORT_RST);
   endproperty
   a_reset_fmt: assert property (p_reset_fmt) // R2
      else $error("format not I2S slave after reset");

   property p_master_drive;
      (isMaster |-> !bitClockOeN && !frameClockOeN) and
      (!isMaster |-> bitClockOeN && frameClockOeN);
   endproperty
   a_master_drive: assert property (p_master_drive) // R7
      else $error("clock pin enables disagree with master bit");

   property p_chan_range;
      sampleOut.valid |-> (sampleOut.channel < 4'(NUM_CHANNELS));
   endproperty
   a_chan_range: assert property (p_chan_range) // R8
      else $error("sample channel out of range");

   property p_stereo_map;
      sampleOut.valid && (slotMode < SLOT_TDM4) |->
         (5'(sampleOut.channel) == {1'b0, outLine_ff, 1'b0} + outSlot_ff);
   endproperty
   a_stereo_map: assert property (p_stereo_map) // R11
      else $error("stereo channel mapping wrong");

   property p_tdm4_lines;
      sampleOut.valid && (slotMode == SLOT_TDM4) |-> (outLine_ff < 3'h3);
   endproperty
   a_tdm4_lines: assert property (p_tdm4_lines) // R12
      else $error("tdm4 used a line above three");

   property p_tdm8_lines;
      sampleOut.valid && (slotMode == SLOT_TDM8) |-> (outLine_ff < 3'h2);
   endproperty
   a_tdm8_lines: assert property (p_tdm8_lines) // R13
      else $error("tdm8 used a line above two");

   property p_tdm16_lines;
      sampleOut.valid && (slotMode == SLOT_TDM16) |->
         (outLine_ff == 3'h0) && (5'(sampleOut.channel) == outSlot_ff);
   endproperty
   a_tdm16_lines: assert property (p_tdm16_lines) // R14
      else $error("tdm16 used a line other than one");

   property p_edge_sel;
      bitTick |-> (bclkSrc == ~fallEdge) && $changed(bclkSrc);
   endproperty
   a_edge_sel: assert property (p_edge_sel) // R6
      else $error("data latched on the wrong bit clock edge");

   property p_rj16_low;
      sampleOut.valid && (align == ALIGN_RIGHT16) |->
         (sampleOut.word[7:0] == 8'h00);
   endproperty
   a_rj16_low: assert property (p_rj16_low) // R3
      else $error("right 16-bit word not padded");

   property p_handover;
      slotEnd |=> wrBusy_ff && (wrLine_ff == 3'h0) ##6 !wrBusy_ff;
   endproperty
   a_handover: assert property (p_handover) // R17
      else $error("slot word not handed over in six cycles");

   property p_pulse_frame;
      isMaster && pulseMode && $stable(portCtrl_ff) && $changed(mPos_ff) |=>
         (frameOut_ff ^ pol) == (mPos_ff == 10'h000);
   endproperty
   a_pulse_frame: assert property (p_pulse_frame) // R9
      else $error("master frame pulse not at frame start");

   property p_clockless;
      intClk && !isMaster |-> bitClockOeN && (bclkSrc == genClk_ff);
   endproperty
   a_clockless: assert property (p_clockless) // R16
      else $error("clockless mode not on internal bit timing");

   c_stereo: cover property (sampleOut.valid && slotMode < SLOT_TDM4);
   c_tdm16: cover property (sampleOut.valid && slotMode == SLOT_TDM16);
   c_master: cover property (isMaster && start);
   c_reg_rd: cover property (dpRead_ff && dpAddr_ff == ADDR_SAMPLE);
endmodule : msa_serial_audio_input
`default_nettype wire

// ---- testbench/msa_audio_source.sv ----
// Behavioural audio source that drives the port in slave mode
`default_nettype none
module msa_audio_source (
   // Serial clocks
   output logic                          bitClk,
   output logic                          frameClk,
   // Data lines, bit 0 is line 1
   output logic [msa_pkg::NUM_LINES-1:0] dataLine
);
   timeunit 1ns;
   timeprecision 1ns;
   import msa_pkg::*;

   // 800 ns bit period keeps every mode far below its rate limit
   localparam int HALF_NS = 400;

   initial begin
      bitClk   = 1'b0;
      frameClk = 1'b1;
      dataLine = '0;
   end

   // Distinct per line and slot so misrouting shows
   function automatic logic [23:0] word_of(input int ln, input int sl);
      return {ln[3:0], sl[3:0], 16'hC35A ^ {ln[7:0], sl[7:0]}};
   endfunction : word_of

   // Clock stands still outside frames; off-word bits toggle
   task automatic frame(input int slots, input int len, input int dly,
                        input int off, input int nb, input bit pulse,
                        input bit pol, input bit fall);
      int          b;
      int          sl;
      logic [23:0] w;
      frameClk = ~pulse ^ pol;
      // One idle bit so the port sees the idle frame level first
      bitClk = fall;
      #HALF_NS;
      bitClk = ~fall;
      #HALF_NS;
      for (int pos = 0; pos <= slots * len + dly; pos++) begin
         b  = (pos - dly) % len - off;
         sl = (pos - dly) / len;
         frameClk = pol ^ (pulse ? (pos == 0)
                                 : (pos >= slots * len / 2));
         for (int ln = 0; ln < NUM_LINES; ln++) begin
            w = word_of(ln, sl);
            dataLine[ln] = (pos >= dly && b >= 0 && b < nb) ?
                           w[23 - b] : ~dataLine[ln];
         end
         // Frame and data move on the non-latching edge only
         bitClk = fall;
         #HALF_NS;
         bitClk = ~fall;
         #HALF_NS;
      end
      bitClk   = 1'b0;
      dataLine = ~dataLine;
   endtask : frame
endmodule : msa_audio_source
`default_nettype wire

// ---- testbench/msa_serial_audio_input_test.sv ----
// Self-checking bench for the serial audio input port
`default_nettype none
module msa_serial_audio_input_test;
   timeunit 1ns;
   timeprecision 1ns;
   import msa_pkg::*;

   logic                 core_clk = 1'b0;
   logic                 srst;
   logic                 hsel;
   logic                 hwrite;
   logic [1:0]           htrans;
   logic [31:0]          haddr;
   logic [31:0]          hwdata;
   logic                 hreadyout;
   logic                 hresp;
   logic [31:0]          hrdata;
   logic                 bitClockOut;
   logic                 bitClockOeN;
   logic                 frameClockOut;
   logic                 frameClockOeN;
   logic                 srcBit;
   logic                 srcFrame;
   logic [NUM_LINES-1:0] srcData;
   msa_sample_t          sampleOut;
   logic [23:0]          got [16];
   logic [15:0]          gotMask;
   int                   n_errors;
   int                   comparisons;
   int                   cycles;

   always #50 core_clk = ~core_clk;

   msa_serial_audio_input #(.BIT_HALF(BIT_HALF_CYCLES)) dut_u (
      .core_clk      (core_clk),
      .srst          (srst),
      .hsel          (hsel),
      .haddr         (haddr),
      .htrans        (htrans),
      .hwrite        (hwrite),
      .hsize         (3'h2),
      .hwdata        (hwdata),
      .hready        (hreadyout),
      .hreadyout     (hreadyout),
      .hresp         (hresp),
      .hrdata        (hrdata),
      .bitClockIn    (bitClockOeN ? srcBit : bitClockOut),
      .bitClockOut   (bitClockOut),
      .bitClockOeN   (bitClockOeN),
      .frameClockIn  (frameClockOeN ? srcFrame : frameClockOut),
      .frameClockOut (frameClockOut),
      .frameClockOeN (frameClockOeN),
      .serialDataLine(srcData),
      .sampleOut     (sampleOut)
   );

   msa_audio_source src_u (
      .bitClk  (srcBit),
      .frameClk(srcFrame),
      .dataLine(srcData)
   );

   always @(posedge core_clk) begin
      if (sampleOut.valid === 1'b1) begin
         got[sampleOut.channel]     <= sampleOut.word;
         gotMask[sampleOut.channel] <= 1'b1;
      end
   end

   // Hang guard, well above the longest frame sequence
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         n_errors = n_errors + 1;
         final_report();
      end
   end

   task automatic final_report;
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] seen);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic ahb(input logic wr, input logic [31:0] addr,
                      input logic [31:0] wdata, output logic [31:0] rdata);
      @(posedge core_clk);
      haddr  <= addr;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wdata;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rdata = hrdata;
   endtask : ahb

   task automatic wr(input logic [31:0] addr, input logic [31:0] data);
      logic [31:0] r;
      ahb(1'b1, addr, data, r);
   endtask : wr

   task automatic rd(input logic [31:0] addr, output logic [31:0] data);
      ahb(1'b0, addr, 32'h0000_0000, data);
   endtask : rd

   task automatic run_case(input logic [7:0] fmt, input logic [7:0] port,
         input int slots, input int len, input int dly, input int off,
         input int nb, input bit pulse, input bit pol, input bit fall);
      logic [23:0] w;
      wr(32'(ADDR_FMT), {24'h00_0000, fmt});
      wr(32'(ADDR_PORT), {24'h00_0000, port});
      gotMask = 16'h0000;
      src_u.frame(slots, len, dly, off, nb, pulse, pol, fall);
      for (int i = 0; i < 200 && gotMask !== 16'h0FFF; i++)
         @(posedge core_clk);
      // Room for stray pulses of channels that must stay silent
      repeat (10) @(posedge core_clk);
      check("channel mask", 32'h0000_0FFF, {16'h0000, gotMask});
      for (int c = 0; c < NUM_CHANNELS; c++) begin
         w = src_u.word_of(c / slots, c % slots);
         if (nb == 16) w = {w[23:8], 8'h00};
         check("channel word", {8'h00, w}, {8'h00, got[c]});
      end
   endtask : run_case

   task automatic t_reset_regs;
      logic [31:0] r;
      rd(32'(ADDR_FMT), r);
      check("format reset", 32'h0000_0001, r);
      rd(32'(ADDR_PORT), r);
      check("port reset", 32'h0000_0000, r);
      check("slave enable", 32'h0000_0003,
            {30'h0, bitClockOeN, frameClockOeN});
      check("response", 32'h0000_0000, {31'h0, hresp});
      wr(32'(ADDR_PORT), 32'hFFFF_FF18);
      rd(32'(ADDR_PORT), r);
      check("port readback", 32'h0000_0018, r);
      wr(32'h0000_03F0, 32'hFFFF_FFFF);
      rd(32'h0000_03F0, r);
      check("unmapped read", 32'h0000_0000, r);
   endtask : t_reset_regs

   task automatic t_i2s_stereo;
      logic [31:0] r;
      logic [23:0] w;
      run_case(8'h01, 8'h00, 2, 32, 1, 0, 24, 0, 0, 0);
      wr(32'(ADDR_CHSEL), 32'h0000_0005);
      rd(32'(ADDR_SAMPLE), r);
      w = src_u.word_of(2, 1);
      check("sample register", {8'h00, w}, r);
   endtask : t_i2s_stereo

   task automatic t_master;
      int   t0;
      int   t1;
      int   f0;
      int   f1;
      int   hi;
      logic last;
      logic lastF;
      wr(32'(ADDR_FMT), 32'h0000_0001);
      // Master with a one-bit frame pulse
      wr(32'(ADDR_PORT), 32'h0000_0041);
      t0    = -1;
      t1    = -1;
      f0    = -1;
      f1    = -1;
      hi    = 0;
      last  = 1'b1;
      lastF = 1'b1;
      for (int i = 0; i < 1200; i++) begin
         @(posedge core_clk);
         if (bitClockOut === 1'b1 && last === 1'b0) begin
            if (t0 < 0) t0 = i;
            else if (t1 < 0) t1 = i;
         end
         if (frameClockOut === 1'b1 && lastF === 1'b0) begin
            if (f0 < 0) f0 = i;
            else if (f1 < 0) f1 = i;
         end
         if (f0 >= 0 && f1 < 0 && frameClockOut === 1'b1) hi = hi + 1;
         last  = bitClockOut;
         lastF = frameClockOut;
      end
      check("bit clock period", 32'(2 * BIT_HALF_CYCLES), 32'(t1 - t0));
      // Two stereo slots of 32 bits, each bit two half periods
      check("frame period", 32'(128 * BIT_HALF_CYCLES), 32'(f1 - f0));
      check("frame pulse width", 32'(2 * BIT_HALF_CYCLES), 32'(hi));
      check("master enable", 32'h0000_0000,
            {30'h0, bitClockOeN, frameClockOeN});
      wr(32'(ADDR_PORT), 32'h0000_0000);
   endtask : t_master

   task automatic t_left_pol;
      run_case(8'h48, 8'h20, 2, 32, 0, 0, 24, 0, 1, 0);
   endtask : t_left_pol

   task automatic t_right24_fall;
      run_case(8'h80, 8'h02, 2, 32, 0, 8, 24, 0, 0, 1);
   endtask : t_right24_fall

   task automatic t_right16;
      run_case(8'hC0, 8'h00, 2, 32, 0, 16, 16, 0, 0, 0);
   endtask : t_right16

   task automatic t_tdm4_pulse;
      run_case(8'h10, 8'h44, 4, 16, 1, 0, 16, 1, 0, 0);
   endtask : t_tdm4_pulse

   task automatic t_tdm8;
      run_case(8'h58, 8'h00, 8, 32, 0, 0, 24, 0, 0, 0);
   endtask : t_tdm8

   task automatic t_tdm16;
      run_case(8'h60, 8'h04, 16, 16, 0, 0, 16, 0, 0, 0);
   endtask : t_tdm16

   initial begin
      srst        = 1'b1;
      hsel        = 1'b1;
      hwrite      = 1'b0;
      htrans      = 2'h0;
      haddr       = 32'h0000_0000;
      hwdata      = 32'h0000_0000;
      gotMask     = 16'h0000;
      n_errors    = 0;
      comparisons = 0;
      cycles      = 0;
      repeat (3) @(posedge core_clk);
      srst <= 1'b0;
      t_reset_regs();
      t_i2s_stereo();
      t_left_pol();
      t_right24_fall();
      t_right16();
      t_tdm4_pulse();
      t_tdm8();
      t_tdm16();
      t_master();
      final_report();
   end
endmodule : msa_serial_audio_input_test
`default_nettype wire
